// file: common/vphy_map.svh
// offsets, field positions, reset values and timing for the emulated phy registers
`ifndef VPHY_MAP_SVH
`define VPHY_MAP_SVH

// bus byte offsets
`define PORT1_VPHY_BASIC_STATE 9'h0c4
`define PORT1_VPHY_IDENT_HIGH  9'h0c8
`define PORT1_VPHY_IDENT_LOW   9'h0cc
`define PORT0_VPHY_BASIC_STATE 9'h1c4
`define PORT0_VPHY_IDENT_HIGH  9'h1c8
`define PORT0_VPHY_IDENT_LOW   9'h1cc

// management register indices
`define MGMT_IDX_BASIC_STATE 5'h01
`define MGMT_IDX_IDENT_HIGH  5'h02
`define MGMT_IDX_IDENT_LOW   5'h03

// basic state bit positions
`define ST_T4         15
`define ST_100X_FD    14
`define ST_100X_HD    13
`define ST_10T_FD     12
`define ST_10T_HD     11
`define ST_T2_FD      10
`define ST_T2_HD      9
`define ST_EXT_STATUS 8
`define ST_PRE_SUPP   6
`define ST_AN_DONE    5
`define ST_REM_FAULT  4
`define ST_AN_ABLE    3
`define ST_LINK_UP    2
`define ST_JABBER     1
`define ST_EXT_CAP    0

// ident low field positions
`define IDL_ORG_MSB   15
`define IDL_ORG_LSB   10
`define IDL_MODEL_MSB 9
`define IDL_MODEL_LSB 4
`define IDL_REV_MSB   3
`define IDL_REV_LSB   0

// reset values and padding
`define IDENT_HIGH_RST 16'h0000
`define IDENT_LOW_RST  16'h0000
`define PAD_ZERO       16'h0000
`define DATA16_ZERO    16'h0000
`define CNT_ZERO       8'h00
`define CNT_ONE        8'h01

// emulated negotiation settle time
`define AN_SETTLE_NS   1000
`define MCLK_PERIOD_NS 20
`define AN_SETTLE_CYCLES ((`AN_SETTLE_NS + `MCLK_PERIOD_NS - 1) / `MCLK_PERIOD_NS)

`endif

// file: common/vphy_pkg.sv
// types for the emulated phy status and identification registers
package vphy_pkg;

    typedef enum logic [1:0] {
        AN_RUN  = 2'b00,
        AN_DONE = 2'b01
    } an_state_t;

    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [8:0]  addr;
        logic [31:0] wdata;
    } bus_req_t;

    typedef struct packed {
        logic        ack;
        logic [31:0] rdata;
    } bus_rsp_t;

    typedef struct packed {
        logic        rd;
        logic        wr;
        logic        port;
        logic [4:0]  idx;
        logic [15:0] wdata;
    } mgmt_req_t;

    typedef struct packed {
        logic        ack;
        logic        hit;
        logic [15:0] rdata;
    } mgmt_rsp_t;

    typedef struct packed {
        logic       hit;
        logic       port;
        logic [4:0] idx;
    } reg_sel_t;

    typedef struct packed {
        an_state_t        an_state;
        logic [7:0]       an_cnt;
        logic [1:0][15:0] id_high;
        logic [1:0][15:0] id_low;
        bus_rsp_t         bus_rsp;
        mgmt_rsp_t        mgmt_rsp;
    } vphy_state_t;

endpackage

// file: design/vphy_status_id_regs.sv
// emulated phy basic state and identification registers for ports 0 and 1
`timescale 1ns/1ps
`default_nettype none
`include "vphy_map.svh"

// Overview of operation
// - state bits 14 and 13 read 1: 100 Mb/s X full and half duplex able.
// - state bits 12 and 11 read 1: 10 Mb/s twisted pair full and half able.
// - state bits 15, 10 and 9 always read 0.
// - state bit 8 reads 0: no extended status, no gigabit.
// - state bit 6 reads 0: preamble-less management frames not accepted.
// - negotiation-complete bit 5 clears on reset, sets shortly after.
// - remote fault 0, link up 1, jabber 0, always.
// - state bit 3 reads 1: negotiation able.
// - state bit 0 reads 1; only management registers 1 to 3 exist.
// - bus bits 31 to 16 read-only zero padding; management view 16 bits.
// - basic state at 1c4 (port 0), 0c4 (port 1), management index 1.
// - ident high at 1c8/0c8, index 2, 16-bit read/write, resets to zero.
// - ident low at 1cc/0cc, index 3: org bits, model, revision fields.
// - all ident fields reset to zero; zero is a legal value.
module vphy_status_id_regs
    import vphy_pkg::*;
(
    // clock and reset
    input  wire logic      mclk,
    input  wire logic      rst,
    // register bus
    input  wire bus_req_t  bus_req,
    output var  bus_rsp_t  bus_rsp,
    // management register port
    input  wire mgmt_req_t mgmt_req,
    output var  mgmt_rsp_t mgmt_rsp,
    // negotiation status
    output logic           an_complete
);

    localparam logic [7:0] AN_LAST = 8'(`AN_SETTLE_CYCLES - 1);

    vphy_state_t r_reg;
    vphy_state_t r_next;
    logic [15:0] state_word;
    reg_sel_t    bus_sel;
    reg_sel_t    mgmt_sel;
    logic [15:0] bus_rd16;
    logic [15:0] mgmt_rd16;

    // fixed and emulated basic state bits
    function automatic logic [15:0] basic_state(input logic an_done);
        logic [15:0] s;
        s = `DATA16_ZERO;
        s[`ST_T4]         = 1'b0;
        s[`ST_100X_FD]    = 1'b1;
        s[`ST_100X_HD]    = 1'b1;
        s[`ST_10T_FD]     = 1'b1;
        s[`ST_10T_HD]     = 1'b1;
        s[`ST_T2_FD]      = 1'b0;
        s[`ST_T2_HD]      = 1'b0;
        s[`ST_EXT_STATUS] = 1'b0;
        s[`ST_PRE_SUPP]   = 1'b0;
        s[`ST_AN_DONE]    = an_done;
        s[`ST_REM_FAULT]  = 1'b0;
        s[`ST_AN_ABLE]    = 1'b1;
        s[`ST_LINK_UP]    = 1'b1;
        s[`ST_JABBER]     = 1'b0;
        s[`ST_EXT_CAP]    = 1'b1;
        return s;
    endfunction

    // bus offset to port and index
    function automatic reg_sel_t decode_bus(input logic [8:0] a);
        reg_sel_t d;
        d = '0;
        unique case (a)
            `PORT0_VPHY_BASIC_STATE: d = '{1'b1, 1'b0, `MGMT_IDX_BASIC_STATE};
            `PORT1_VPHY_BASIC_STATE: d = '{1'b1, 1'b1, `MGMT_IDX_BASIC_STATE};
            `PORT0_VPHY_IDENT_HIGH:  d = '{1'b1, 1'b0, `MGMT_IDX_IDENT_HIGH};
            `PORT1_VPHY_IDENT_HIGH:  d = '{1'b1, 1'b1, `MGMT_IDX_IDENT_HIGH};
            `PORT0_VPHY_IDENT_LOW:   d = '{1'b1, 1'b0, `MGMT_IDX_IDENT_LOW};
            `PORT1_VPHY_IDENT_LOW:   d = '{1'b1, 1'b1, `MGMT_IDX_IDENT_LOW};
            default:                 d = '0;
        endcase
        return d;
    endfunction

    // shared read mux for both views
    function automatic logic [15:0] read_reg(
        input reg_sel_t         s,
        input logic [15:0]      st,
        input logic [1:0][15:0] hi,
        input logic [1:0][15:0] lo
    );
        logic [15:0] v;
        v = `DATA16_ZERO;
        if (s.hit) begin
            unique case (s.idx)
                `MGMT_IDX_BASIC_STATE: v = st;
                `MGMT_IDX_IDENT_HIGH:  v = hi[s.port];
                `MGMT_IDX_IDENT_LOW:   v = lo[s.port];
                default:               v = `DATA16_ZERO;
            endcase
        end
        return v;
    endfunction

    always_comb begin
        state_word = basic_state(r_reg.an_state == AN_DONE);
        bus_sel    = decode_bus(bus_req.addr);
        // management registers 1 to 3 live here
        mgmt_sel.hit  = (mgmt_req.idx == `MGMT_IDX_BASIC_STATE) ||
                        (mgmt_req.idx == `MGMT_IDX_IDENT_HIGH) ||
                        (mgmt_req.idx == `MGMT_IDX_IDENT_LOW);
        mgmt_sel.port = mgmt_req.port;
        mgmt_sel.idx  = mgmt_req.idx;
        bus_rd16  = read_reg(bus_sel, state_word, r_reg.id_high, r_reg.id_low);
        mgmt_rd16 = read_reg(mgmt_sel, state_word, r_reg.id_high, r_reg.id_low);
    end

    always_comb begin
        r_next = r_reg;
        r_next.bus_rsp.ack  = 1'b0;
        r_next.mgmt_rsp.ack = 1'b0;

        // emulated negotiation settles after reset
        unique case (r_reg.an_state)
            AN_RUN: begin
                if (r_reg.an_cnt == AN_LAST) begin
                    r_next.an_state = AN_DONE;
                end else begin
                    r_next.an_cnt = r_reg.an_cnt + `CNT_ONE;
                end
            end
            AN_DONE: begin
                r_next.an_state = AN_DONE;
            end
        endcase

        // read answers, one cycle after the strobe
        if (bus_req.rd) begin
            r_next.bus_rsp.ack   = 1'b1;
            r_next.bus_rsp.rdata = {`PAD_ZERO, bus_rd16};
        end
        if (mgmt_req.rd) begin
            r_next.mgmt_rsp.ack   = 1'b1;
            r_next.mgmt_rsp.hit   = mgmt_sel.hit;
            r_next.mgmt_rsp.rdata = mgmt_rd16;
        end

        // management writes, 16-bit view
        if (mgmt_req.wr && mgmt_sel.hit) begin
            unique case (mgmt_sel.idx)
                `MGMT_IDX_IDENT_HIGH: r_next.id_high[mgmt_sel.port] = mgmt_req.wdata;
                `MGMT_IDX_IDENT_LOW:  r_next.id_low[mgmt_sel.port]  = mgmt_req.wdata;
                default:              r_next.id_low = r_next.id_low;
            endcase
        end

        // bus writes, upper half dropped; bus wins a same-cycle clash
        if (bus_req.wr && bus_sel.hit) begin
            unique case (bus_sel.idx)
                `MGMT_IDX_IDENT_HIGH: r_next.id_high[bus_sel.port] = bus_req.wdata[15:0];
                `MGMT_IDX_IDENT_LOW: begin
                    r_next.id_low[bus_sel.port][`IDL_ORG_MSB:`IDL_ORG_LSB] =
                        bus_req.wdata[`IDL_ORG_MSB:`IDL_ORG_LSB];
                    r_next.id_low[bus_sel.port][`IDL_MODEL_MSB:`IDL_MODEL_LSB] =
                        bus_req.wdata[`IDL_MODEL_MSB:`IDL_MODEL_LSB];
                    r_next.id_low[bus_sel.port][`IDL_REV_MSB:`IDL_REV_LSB] =
                        bus_req.wdata[`IDL_REV_MSB:`IDL_REV_LSB];
                end
                default: r_next.id_low = r_next.id_low;
            endcase
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            r_reg.an_state <= AN_RUN;
            r_reg.an_cnt   <= `CNT_ZERO;
            r_reg.id_high  <= {2{`IDENT_HIGH_RST}};
            r_reg.id_low   <= {2{`IDENT_LOW_RST}};
            r_reg.bus_rsp  <= '0;
            r_reg.mgmt_rsp <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign bus_rsp     = r_reg.bus_rsp;
    assign mgmt_rsp    = r_reg.mgmt_rsp;
    assign an_complete = (r_reg.an_state == AN_DONE);

    // checks
    logic st_rd;
    logic id_rd_hi;
    assign st_rd = bus_req.rd && (bus_req.addr == `PORT0_VPHY_BASIC_STATE ||
                                  bus_req.addr == `PORT1_VPHY_BASIC_STATE);
    assign id_rd_hi = bus_req.rd && bus_req.addr == `PORT0_VPHY_IDENT_HIGH;

    a_caps_100x: assert property (@(posedge mclk) disable iff (rst)
        st_rd |=> bus_rsp.ack && bus_rsp.rdata[14:13] == 2'b11)
        else $error("100x capability bits not set");

    a_caps_10t: assert property (@(posedge mclk) disable iff (rst)
        st_rd |=> bus_rsp.rdata[12:11] == 2'b11)
        else $error("10t capability bits not set");

    a_no_t4_t2: assert property (@(posedge mclk) disable iff (rst)
        st_rd |=> !bus_rsp.rdata[15] && bus_rsp.rdata[10:9] == 2'b00)
        else $error("t4 or t2 capability reported");

    a_no_ext_stat: assert property (@(posedge mclk) disable iff (rst)
        st_rd |=> !bus_rsp.rdata[8])
        else $error("extended status reported");

    a_no_pre_supp: assert property (@(posedge mclk) disable iff (rst)
        (mgmt_req.rd && mgmt_req.idx == `MGMT_IDX_BASIC_STATE)
            |=> mgmt_rsp.hit && !mgmt_rsp.rdata[6])
        else $error("preamble suppression reported");

    a_an_settle: assert property (@(posedge mclk) disable iff (rst)
        $rose(an_complete) |-> $past(r_reg.an_cnt) == AN_LAST)
        else $error("negotiation completed at wrong time");

    a_an_tracks: assert property (@(posedge mclk) disable iff (rst)
        st_rd |=> bus_rsp.rdata[5] == $past(an_complete))
        else $error("negotiation bit does not track state");

    a_link_fixed: assert property (@(posedge mclk) disable iff (rst)
        st_rd |=> bus_rsp.rdata[4] == 1'b0 && bus_rsp.rdata[2] && !bus_rsp.rdata[1])
        else $error("link, fault or jabber bit wrong");

    a_an_able: assert property (@(posedge mclk) disable iff (rst)
        st_rd |=> bus_rsp.rdata[3] && bus_rsp.rdata[0])
        else $error("negotiation or extended capability bit clear");

    a_pad_zero: assert property (@(posedge mclk) disable iff (rst)
        bus_rsp.ack |-> bus_rsp.rdata[31:16] == `PAD_ZERO)
        else $error("padding bits not zero");

    a_mgmt_range: assert property (@(posedge mclk) disable iff (rst)
        (mgmt_req.rd && mgmt_req.idx > `MGMT_IDX_IDENT_LOW)
            |=> !mgmt_rsp.hit && mgmt_rsp.rdata == `DATA16_ZERO)
        else $error("unimplemented index answered");

    a_state_ro: assert property (@(posedge mclk) disable iff (rst)
        (bus_req.wr && bus_req.addr == `PORT0_VPHY_BASIC_STATE && !mgmt_req.wr)
            |=> $stable(r_reg.id_high) && $stable(r_reg.id_low))
        else $error("state write changed storage");

    a_shared_view: assert property (@(posedge mclk) disable iff (rst)
        (mgmt_req.wr && !mgmt_req.port && mgmt_req.idx == `MGMT_IDX_IDENT_HIGH
            && !bus_req.wr) ##2 id_rd_hi
            |=> bus_rsp.rdata[15:0] == $past(mgmt_req.wdata, 3))
        else $error("management write not seen on bus");

endmodule
`default_nettype wire

// file: verif/mgmt_station_model.sv
// management station model on the emulated phy management register port
`timescale 1ns/1ps
`default_nettype none
module mgmt_station_model
    import vphy_pkg::*;
(
    // clock
    input  wire logic      mclk,
    // management register port
    output var  mgmt_req_t mgmt_req,
    input  wire mgmt_rsp_t mgmt_rsp
);
    initial begin
        mgmt_req = '0;
    end

    // one-cycle strobe, then released lines show the inverse
    task automatic issue(input logic wr, input logic port, input logic [4:0] idx,
                         input logic [15:0] wdata);
        @(posedge mclk);
        #1;
        mgmt_req = '{rd: ~wr, wr: wr, port: port, idx: idx, wdata: wdata};
        @(posedge mclk);
        #1;
        mgmt_req = '{rd: 1'b0, wr: 1'b0, port: ~port, idx: ~idx, wdata: ~wdata};
    endtask

    // read with a bounded wait for the answer
    task automatic read(input logic port, input logic [4:0] idx, output logic [15:0] data,
                        output logic hit, output logic ok);
        int n;
        issue(1'b0, port, idx, 16'h0000);
        ok = 1'b0;
        for (n = 0; n < 4 && !ok; n++) begin
            if (mgmt_rsp.ack === 1'b1) begin
                ok = 1'b1;
            end else begin
                @(posedge mclk);
                #1;
            end
        end
        data = mgmt_rsp.rdata;
        hit  = mgmt_rsp.hit;
    endtask
endmodule
`default_nettype wire

// file: verif/virtual_phy_status_id_regs_tb.sv
// testbench for the emulated phy status and identification registers
`timescale 1ns/1ps
`default_nettype none
`include "vphy_map.svh"
module virtual_phy_status_id_regs_tb
    import vphy_pkg::*;
;
    // state bits 14..11, 3, 2, 0 set; bit 5 once negotiation is done
    localparam logic [31:0] ST_RUN  = 32'h0000_780d;
    localparam logic [31:0] ST_DONE = 32'h0000_782d;
    localparam logic [8:0]  IDS [4] = '{`PORT0_VPHY_IDENT_HIGH, `PORT0_VPHY_IDENT_LOW,
                                        `PORT1_VPHY_IDENT_HIGH, `PORT1_VPHY_IDENT_LOW};
    logic        mclk;
    logic        rst;
    bus_req_t    bus_req;
    bus_rsp_t    bus_rsp;
    mgmt_req_t   mgmt_req;
    mgmt_rsp_t   mgmt_rsp;
    logic        an_complete;
    logic [15:0] md;
    logic        mh;
    logic        mok;
    int          err_count;
    int          comparisons;
    int          cyc;
    int          n;

    vphy_status_id_regs vphy_status_id_regs_inst (
        .mclk        (mclk),
        .rst         (rst),
        .bus_req     (bus_req),
        .bus_rsp     (bus_rsp),
        .mgmt_req    (mgmt_req),
        .mgmt_rsp    (mgmt_rsp),
        .an_complete (an_complete)
    );

    mgmt_station_model mgmt_station_model_inst (
        .mclk     (mclk),
        .mgmt_req (mgmt_req),
        .mgmt_rsp (mgmt_rsp)
    );

    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    always @(posedge mclk or posedge rst) begin
        if (rst) cyc <= 0;
        else cyc <= cyc + 1;
    end

    task automatic stop_test();
        $display("comparisons %0d err_count %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic bus_go(input logic rd, input logic [8:0] addr, input logic [31:0] wdata);
        @(posedge mclk);
        #1;
        bus_req = '{rd: rd, wr: ~rd, addr: addr, wdata: wdata};
        @(posedge mclk);
        #1;
        bus_req = '{rd: 1'b0, wr: 1'b0, addr: ~addr, wdata: ~wdata};
    endtask

    task automatic bus_rd(input logic [8:0] addr, input logic [31:0] exp);
        int k;
        bus_go(1'b1, addr, 32'h0000_0000);
        for (k = 0; k < 4 && bus_rsp.ack !== 1'b1; k++) begin
            @(posedge mclk);
            #1;
        end
        if (k == 4) begin
            err_count++;
            stop_test();
        end
        chk($sformatf("bus read %h", addr), exp, bus_rsp.rdata);
    endtask

    task automatic m_rd(input logic port, input logic [4:0] idx, input logic [15:0] exp,
                        input logic eh);
        mgmt_station_model_inst.read(port, idx, md, mh, mok);
        if (mok !== 1'b1) begin
            err_count++;
            stop_test();
        end
        chk($sformatf("mgmt read %0d %0d", port, idx), {16'h0000, exp}, {16'h0000, md});
        chk("mgmt hit", {31'h0, eh}, {31'h0, mh});
    endtask

    // register view straight after a reset
    task automatic reset_view();
        chk("an_complete", 32'h0, {31'h0, an_complete});
        bus_rd(`PORT0_VPHY_BASIC_STATE, ST_RUN);
        bus_rd(`PORT1_VPHY_BASIC_STATE, ST_RUN);
        m_rd(1'b1, `MGMT_IDX_BASIC_STATE, ST_RUN[15:0], 1'b1);
        foreach (IDS[i]) bus_rd(IDS[i], 32'h0);
    endtask

    initial begin
        rst = 1'b1;
        bus_req = '0;
        err_count = 0;
        comparisons = 0;
        repeat (6) @(posedge mclk);
        #1;
        rst = 1'b0;
        reset_view();
        for (n = 0; n < 80 && an_complete !== 1'b1; n++) begin
            @(posedge mclk);
            #1;
        end
        chk("an settle", `AN_SETTLE_CYCLES, cyc);
        bus_rd(`PORT0_VPHY_BASIC_STATE, ST_DONE);
        m_rd(1'b0, `MGMT_IDX_BASIC_STATE, ST_DONE[15:0], 1'b1);
        // shared storage between the two views
        bus_go(1'b0, `PORT0_VPHY_IDENT_HIGH, 32'hffff_a5c3);
        bus_rd(`PORT0_VPHY_IDENT_HIGH, 32'h0000_a5c3);
        m_rd(1'b0, `MGMT_IDX_IDENT_HIGH, 16'ha5c3, 1'b1);
        m_rd(1'b1, `MGMT_IDX_IDENT_HIGH, 16'h0000, 1'b1);
        mgmt_station_model_inst.issue(1'b1, 1'b1, `MGMT_IDX_IDENT_LOW, 16'hfc3a);
        bus_rd(`PORT1_VPHY_IDENT_LOW, 32'h0000_fc3a);
        bus_rd(`PORT0_VPHY_IDENT_LOW, 32'h0);
        bus_go(1'b0, `PORT0_VPHY_IDENT_LOW, 32'h1234_ffff);
        m_rd(1'b0, `MGMT_IDX_IDENT_LOW, 16'hffff, 1'b1);
        mgmt_station_model_inst.issue(1'b1, 1'b0, `MGMT_IDX_IDENT_HIGH, 16'h0000);
        bus_rd(`PORT0_VPHY_IDENT_HIGH, 32'h0);
        // writes to the basic state are ignored
        bus_go(1'b0, `PORT0_VPHY_BASIC_STATE, 32'h0000_0000);
        mgmt_station_model_inst.issue(1'b1, 1'b1, `MGMT_IDX_BASIC_STATE, 16'h87f2);
        bus_rd(`PORT0_VPHY_BASIC_STATE, ST_DONE);
        bus_rd(`PORT1_VPHY_BASIC_STATE, ST_DONE);
        // unmapped places
        bus_rd(9'h1d0, 32'h0);
        mgmt_station_model_inst.issue(1'b1, 1'b0, 5'h04, 16'hffff);
        m_rd(1'b0, 5'h04, 16'h0000, 1'b0);
        m_rd(1'b1, 5'h00, 16'h0000, 1'b0);
        bus_rd(`PORT0_VPHY_IDENT_HIGH, 32'h0);
        // second reset in mid-run
        @(posedge mclk);
        #1;
        rst = 1'b1;
        repeat (2) @(posedge mclk);
        #1;
        rst = 1'b0;
        reset_view();
        stop_test();
    end
endmodule
`default_nettype wire
